//--- verilog/sram_ctrl.sv
// Controller that runs read and write cycles on an asynchronous static memory
`timescale 1ns/1ps
module sram_ctrl (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire sram_ctrl_pkg::user_req_s req_i,
  output logic ready_o,
  output logic rvalid_o,
  output logic [sram_ctrl_pkg::DATA_W-1:0] rdata_o,
  output logic [sram_ctrl_pkg::ADDR_W-1:0] mem_addr_o,
  output logic mem_sel_n_o,
  output logic mem_oe_n_o,
  output logic mem_we_n_o,
  output logic [sram_ctrl_pkg::DATA_W-1:0] mem_dq_o,
  output logic mem_dq_oe_o,
  input wire logic [sram_ctrl_pkg::DATA_W-1:0] mem_dq_i
);
  import sram_ctrl_pkg::*;

  typedef struct packed {
    ctrl_state_e st;
    mem_pins_s pins;
    logic ready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
  } ctrl_s;

  localparam mem_pins_s PINS_IDLE = '{addr: '0, sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                      dq_o: '0, dq_oe: 1'b0};

  ctrl_s s_q;
  ctrl_s s_d;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_val;
  logic tmr_done;

  ////////////////////////////////////////////////////////////////////////////
  sram_ctrl_timer #(
    .W(CNT_W)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(tmr_load),
    .value_i(tmr_val),
    .done_o(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    tmr_load = 1'b0;
    tmr_val = '0;
    case (s_q.st)
      ST_IDLE: begin
        s_d.ready = 1'b1;
        if (req_i.valid && s_q.ready) begin
          s_d.ready = 1'b0;
          tmr_load = 1'b1;
          // Address and select change on the same edge, so address is never late
          s_d.pins.addr = req_i.addr;
          s_d.pins.sel_n = 1'b0;
          if (req_i.write) begin
            // Strobe falls with select, so the memory never drives the bus
            s_d.pins.we_n = 1'b0;
            s_d.pins.oe_n = 1'b1;
            s_d.pins.dq_o = req_i.wdata;
            s_d.pins.dq_oe = 1'b1;
            tmr_val = CNT_W'(WR_CYC);
            s_d.st = ST_WRITE;
          end else begin
            s_d.pins.oe_n = 1'b0;
            s_d.pins.we_n = 1'b1;
            // Read held for full access time, also bounding cycle spacing
            tmr_val = CNT_W'(RD_CYC);
            s_d.st = ST_READ;
          end
        end
      end
      ST_READ: begin
        if (tmr_done) begin
          // Sample only after access time has elapsed
          s_d.rdata = mem_dq_i;
          s_d.rvalid = 1'b1;
          s_d.pins.sel_n = 1'b1;
          s_d.pins.oe_n = 1'b1;
          tmr_load = 1'b1;
          // Wait out the memory's float time before anyone may drive
          tmr_val = CNT_W'(TURN_CYC);
          s_d.st = ST_TURN;
        end
      end
      ST_WRITE: begin
        if (tmr_done) begin
          // Strobe and select rise together, data held past the end
          // Pulse covers strobe width, select width and data set-up
          s_d.pins.we_n = 1'b1;
          s_d.pins.sel_n = 1'b1;
          s_d.st = ST_TURN;
          tmr_load = 1'b1;
          tmr_val = CNT_W'(1);
        end
      end
      ST_TURN: begin
        // Drivers off one cycle after write end gives zero-hold margin
        s_d.pins.dq_oe = 1'b0;
        if (tmr_done) begin
          s_d.ready = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
        s_d.pins = PINS_IDLE;
        s_d.ready = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{st: ST_IDLE, pins: PINS_IDLE, ready: 1'b0, rvalid: 1'b0, rdata: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign ready_o = s_q.ready;
  assign rvalid_o = s_q.rvalid;
  assign rdata_o = s_q.rdata;
  assign mem_addr_o = s_q.pins.addr;
  assign mem_sel_n_o = s_q.pins.sel_n;
  assign mem_oe_n_o = s_q.pins.oe_n;
  assign mem_we_n_o = s_q.pins.we_n;
  assign mem_dq_o = s_q.pins.dq_o;
  assign mem_dq_oe_o = s_q.pins.dq_oe;
endmodule

//--- verilog/sram_ctrl_pkg.sv
// Package: timing constants, states and carrier structs for the static memory controller
// Behaviour
// - Controller spaces read cycles at least 10 ns, address change to change.
// - Controller has address valid by the falling edge of select.
// - Write happens only while select and strobe both low; ends when either rises.
// - Controller holds write strobe low at least 7 ns.
// - Controller keeps select low at least 7 ns before write end.
// - Controller has write data valid at least 5 ns before write end.
// - With drive enable low, write pulse covers turn-off plus data set-up.
// - Controller drives no write data while memory still drives the bus.
package sram_ctrl_pkg;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_PS = 8000;

  // Figures in picoseconds, as printed in ns
  localparam int T_READ_CYCLE_PS = 10000;
  localparam int T_ADDR_ACCESS_PS = 10000;
  localparam int T_WRITE_PULSE_PS = 7000;
  localparam int T_SEL_TO_END_PS = 7000;
  localparam int T_DATA_SETUP_PS = 5000;
  localparam int T_WE_TO_HIZ_PS = 5000;
  localparam int T_DESEL_HIZ_PS = 5000;

  // Least times round up; data sampled after a longest access rounds up, plus one more cycle
  localparam int RD_CYC = (T_ADDR_ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
  localparam int WR_PULSE_MIN = (T_WRITE_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WR_OVERLAP = (T_WE_TO_HIZ_PS + T_DATA_SETUP_PS + CLK_PERIOD_PS - 1)
                              / CLK_PERIOD_PS;
  localparam int WR_CYC = (WR_OVERLAP > WR_PULSE_MIN) ? WR_OVERLAP : WR_PULSE_MIN;
  localparam int TURN_CYC = (T_DESEL_HIZ_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 4;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_TURN
  } ctrl_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic sel_n;
    logic oe_n;
    logic we_n;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe;
  } mem_pins_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } user_req_s;

endpackage

//--- verilog/sram_ctrl_timer.sv
// Down counter that marks the end of a timed phase
`timescale 1ns/1ps
module sram_ctrl_timer #(
  parameter int W = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic done_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load_i) begin
      cnt_d = value_i;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Done in the last counted cycle, so the phase lasts exactly value_i cycles
  assign done_o = (cnt_q == {{(W-1){1'b0}}, 1'b1});
endmodule

//--- verification/sram_ctrl_properties.sv
// Pin timing and ordering checker for the static memory controller
`timescale 1ns/1ps
module sram_ctrl_properties (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ready_o,
  input wire logic rvalid_o,
  input wire logic [7:0] rdata_o,
  input wire logic [16:0] mem_addr_o,
  input wire logic mem_sel_n_o,
  input wire logic mem_oe_n_o,
  input wire logic mem_we_n_o,
  input wire logic [7:0] mem_dq_o,
  input wire logic mem_dq_oe_o,
  input wire logic [7:0] mem_dq_i
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rd_hold;
    ##1 (!mem_oe_n_o && $stable(mem_addr_o))[*2] ##1 mem_oe_n_o;
  endsequence
  sequence s_wr_hold;
    !mem_we_n_o ##1 !mem_we_n_o ##1 mem_we_n_o;
  endsequence
  chk_idle_bus_free: assert property (ready_o |-> mem_sel_n_o && !mem_dq_oe_o)
    else $error("bus busy while idle");
  chk_write_pulse_len: assert property ($fell(mem_we_n_o) |-> s_wr_hold)
    else $error("write pulse length");
  chk_write_sel_oe: assert property (!mem_we_n_o |-> !mem_sel_n_o && mem_oe_n_o)
    else $error("write without select");
  chk_write_data_hold: assert property (!mem_we_n_o |-> mem_dq_oe_o ##1
    (mem_dq_oe_o && $stable(mem_dq_o))) else $error("write data moved");
  chk_read_no_drive: assert property (!mem_oe_n_o |-> !mem_dq_oe_o && mem_we_n_o)
    else $error("contention in read");
  chk_read_span: assert property ($fell(mem_oe_n_o) |-> s_rd_hold)
    else $error("read span");
  chk_read_answer: assert property ($fell(mem_oe_n_o) |-> ##3 rvalid_o)
    else $error("read answer late");
  chk_read_data_take: assert property (rvalid_o |-> rdata_o == $past(mem_dq_i))
    else $error("read data");
endmodule
bind sram_ctrl sram_ctrl_properties i_sram_ctrl_properties (.*);

//--- verification/sram_mem_model.sv
// Behavioural static memory with data bus resolution
`timescale 1ns/1ps
module sram_mem_model (
  input wire logic [16:0] addr_i,
  input wire logic sel_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [7:0] host_dq_i,
  input wire logic host_oe_i,
  output logic [7:0] bus_o
);
  logic [7:0] mem [0:131071];
  logic [7:0] last_q = 8'h00;
  logic wr_q = 1'b0;
  wire drive = !sel_n_i && !oe_n_i && we_n_i;
  wire drive_soon;
  wire drive_late;
  wire [16:0] addr_hold;
  wire [16:0] addr_settled;
  // Worst case: pins turn on early, data arrives late, drivers linger after release
  assign #3 drive_soon = drive;
  assign #5 drive_late = drive;
  assign #4 addr_hold = addr_i;
  assign #10 addr_settled = addr_i;
  wire driven = drive_soon || drive_late;
  wire valid = drive && drive_late && (addr_settled == addr_i);
  wire old = driven && (!drive || addr_hold != addr_i);
  // Byte lands when the overlap ends, as either strobe rises; a clash corrupts it
  always @(sel_n_i, we_n_i) begin
    if (wr_q && (sel_n_i || we_n_i)) mem[addr_i] = bus_o;
    wr_q = !sel_n_i && !we_n_i;
  end
  always @* if (valid) last_q = mem[addr_i];
  // Clash inverts host data; a floating bus inverts the last byte, so a late sample fails
  assign bus_o = host_oe_i ? (driven ? ~host_dq_i : host_dq_i) :
                 valid ? mem[addr_i] : old ? last_q : ~last_q;
endmodule

//--- verification/sram_ctrl_bench.sv
// Testbench of the static memory controller
`timescale 1ns/1ps
module async_sram_128k_x8_port_bench;
  import sram_ctrl_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  user_req_s req = '0;
  logic ready, rvalid, sel_n, oe_n, we_n, dq_oe;
  logic [7:0] rdata, dq_o, bus;
  logic [16:0] addr;
  int mismatches = 0;
  int n_checks = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  sram_ctrl i_sram_ctrl (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req),
    .ready_o(ready), .rvalid_o(rvalid), .rdata_o(rdata), .mem_addr_o(addr),
    .mem_sel_n_o(sel_n), .mem_oe_n_o(oe_n), .mem_we_n_o(we_n), .mem_dq_o(dq_o),
    .mem_dq_oe_o(dq_oe), .mem_dq_i(bus));
  sram_mem_model i_sram_mem_model (.addr_i(addr), .sel_n_i(sel_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .host_dq_i(dq_o), .host_oe_i(dq_oe), .bus_o(bus));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_for(input bit want_rvalid);
    int i;
    for (i = 0; i < 20 && (want_rvalid ? rvalid : ready) !== 1'b1; i++) @(negedge sys_clk_i);
    if (i == 20) begin
      mismatches++;
      end_of_test();
    end
  endtask
  task automatic issue(input logic w, input logic [16:0] a, input logic [7:0] d);
    wait_for(1'b0);
    req = '{1'b1, w, a, d};
    @(negedge sys_clk_i);
    req.valid = 1'b0;
  endtask
  task automatic rd(input logic [16:0] a, input logic [7:0] exp);
    issue(1'b0, a, 8'h00);
    wait_for(1'b1);
    check(rdata, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_pins();
    check({4'h0, sel_n, oe_n, we_n, dq_oe}, 8'h0e);
    check({7'h0, ready}, 8'h00);
  endtask
  task automatic t_bounds();
    issue(1'b1, 17'h00000, 8'ha5);
    issue(1'b1, 17'h1ffff, 8'h5a);
    rd(17'h00000, 8'ha5);
    rd(17'h1ffff, 8'h5a);
  endtask
  // Distinct bytes at every single-bit address expose a stuck or shorted address line
  task automatic t_addr_lines();
    for (int k = 0; k < 17; k++) issue(1'b1, 17'h00001 << k, 8'h40 + 8'(k));
    for (int k = 0; k < 17; k++) rd(17'h00001 << k, 8'h40 + 8'(k));
  endtask
  // A request while busy is dropped without a sign; the byte must survive
  task automatic t_refused();
    issue(1'b0, 17'h00000, 8'h00);
    @(negedge sys_clk_i);
    req = '{1'b1, 1'b1, 17'h00000, 8'h3c};
    @(negedge sys_clk_i);
    req.valid = 1'b0;
    rd(17'h00000, 8'ha5);
  endtask
  task automatic t_idle();
    wait_for(1'b0);
    check({6'h0, sel_n, dq_oe}, 8'h02);
  endtask
  initial begin
    repeat (5) @(negedge sys_clk_i);
    t_reset_pins();
    rst_n_i = 1'b1;
    t_bounds();
    t_addr_lines();
    t_refused();
    t_idle();
    end_of_test();
  end
endmodule
